/* File: hw/dcl_ctrl.sv */
/*
 Command list controller: pointer handshake registers, block fetch,
 chaining, status write-back, host interrupt, boot load, RAM guard.
 Assumes synchronous inputs, an AXI4-Lite master, a host memory bus
 that acknowledges each request, and an executor for disk commands.
*/
`timescale 1ns/100ps
module dcl_ctrl #(
  parameter int IRQ_LEVELS = 16
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // AXI4-Lite slave
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Host memory bus master
  output dcl_pkg::dcl_mem_req_s o_mem,
  input wire logic i_mem_ack,
  input wire logic [15:0] i_mem_rdata,
  // Disk command executor
  output logic o_exec_start,
  output dcl_pkg::dcl_exec_s o_exec,
  input wire logic i_exec_done,
  input wire logic i_exec_err,
  input wire logic [7:0] i_exec_status,
  // Controller RAM write port
  input wire logic i_ram_wr_valid,
  input wire logic [15:0] i_ram_wr_addr,
  input wire logic [15:0] i_ram_wr_data,
  output logic o_ram_we,
  output logic [15:0] o_ram_addr,
  output logic [15:0] o_ram_wdata,
  output logic o_ram_wr_reject,
  // Straps and host side lines
  input wire logic i_boot_strap,
  input wire logic i_host_reset_strap,
  input wire logic [3:0] i_irq_level_strap,
  output logic o_host_powerup_reset_line_b,
  output logic o_controller_attention_irq,
  output logic [IRQ_LEVELS-1:0] o_host_irq
);
  initial begin
    if (IRQ_LEVELS < 1 || IRQ_LEVELS > 16) begin
      $error("IRQ_LEVELS must be 1 to 16");
    end
  end

  function automatic logic [18:0] word_addr(input logic [18:0] base,
                                            input logic [3:0] idx);
    word_addr = base + {14'h0, idx, 1'b0};
  endfunction : word_addr

  logic [15:0] ctrl_r;
  logic accept_r;
  logic busy_r;
  logic irq_issued_r;
  logic [1:0] byte_cnt_r;
  logic [18:0] ptr_r;
  logic start_r;
  logic boot_pend_r;
  logic first_r;
  dcl_pkg::dcl_state_e state_r;
  logic [3:0] widx_r;
  logic [15:0] blk_r [dcl_pkg::BLK_WORDS];
  logic err_r;
  logic [7:0] sts_r;
  logic core_rst;
  logic host_byte_strobe;
  logic [18:0] link;

  assign core_rst = !i_rst_b || ctrl_r[dcl_pkg::CTRL_RST_BIT];
  assign host_byte_strobe = ctrl_r[dcl_pkg::CTRL_CUE_BIT];
  assign link = {blk_r[dcl_pkg::W_LINK_HI][2:0],
                 blk_r[dcl_pkg::W_LINK_LO]};

  // Register bus writes; both channels taken together
  logic wr_go;
  assign wr_go = i_awvalid && i_wvalid && !o_awready && !o_bvalid;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= dcl_pkg::RESP_OKAY;
      ctrl_r <= 16'h0000;
    end else begin
      o_awready <= wr_go;
      o_wready <= wr_go;
      if (wr_go) begin
        o_bvalid <= 1'b1;
        if (i_awaddr == dcl_pkg::REG_CTRL) begin
          o_bresp <= dcl_pkg::RESP_OKAY;
          if (i_wstrb[0]) begin
            ctrl_r[7:0] <= i_wdata[7:0];
          end
          if (i_wstrb[1]) begin
            ctrl_r[15:8] <= i_wdata[15:8];
          end
        end else if (i_awaddr == dcl_pkg::REG_STATUS ||
                     i_awaddr == dcl_pkg::REG_POINTER) begin
          o_bresp <= dcl_pkg::RESP_OKAY;
        end else begin
          o_bresp <= dcl_pkg::RESP_SLVERR;
        end
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Register bus reads
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= dcl_pkg::RESP_OKAY;
    end else begin
      o_arready <= i_arvalid && !o_arready && !o_rvalid;
      if (i_arvalid && !o_arready && !o_rvalid) begin
        o_rvalid <= 1'b1;
        o_rresp <= dcl_pkg::RESP_OKAY;
        if (i_araddr == dcl_pkg::REG_CTRL) begin
          o_rdata <= {16'h0000, ctrl_r};
        end else if (i_araddr == dcl_pkg::REG_STATUS) begin
          o_rdata <= {16'h0000, irq_issued_r, 2'b00, busy_r, accept_r,
                      11'h000};
        end else if (i_araddr == dcl_pkg::REG_POINTER) begin
          o_rdata <= {13'h0000, ptr_r};
        end else begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= dcl_pkg::RESP_SLVERR;
        end
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // Pointer handshake, one byte per cue
  always_ff @(posedge i_clk_sys) begin
    if (core_rst) begin
      accept_r <= 1'b0;
      byte_cnt_r <= 2'h0;
      ptr_r <= 19'h00000;
      start_r <= 1'b0;
      o_controller_attention_irq <= 1'b0;
    end else begin
      start_r <= 1'b0;
      o_controller_attention_irq <= host_byte_strobe;
      if (host_byte_strobe && !accept_r && state_r == dcl_pkg::ST_IDLE) begin
        accept_r <= 1'b1;
        if (ctrl_r[dcl_pkg::CTRL_CMD_BIT]) begin
          ptr_r[18:15] <= ctrl_r[3:0];
          byte_cnt_r <= 2'h1;
        end else if (byte_cnt_r == 2'h1) begin
          ptr_r[14:7] <= ctrl_r[7:0];
          byte_cnt_r <= 2'h2;
        end else if (byte_cnt_r == 2'h2) begin
          ptr_r[6:0] <= ctrl_r[7:1];
          byte_cnt_r <= dcl_pkg::PTR_BYTES;
        end
      end else if (!host_byte_strobe && accept_r) begin
        accept_r <= 1'b0;
        if (byte_cnt_r == dcl_pkg::PTR_BYTES) begin
          start_r <= 1'b1;
          byte_cnt_r <= 2'h0;
        end
      end else if (state_r == dcl_pkg::ST_WSTAT && i_mem_ack && !err_r &&
                   link != 19'h00000) begin
        ptr_r <= link;
      end
    end
  end

  // Command block engine
  always_ff @(posedge i_clk_sys) begin
    if (core_rst) begin
      state_r <= dcl_pkg::ST_IDLE;
      busy_r <= 1'b0;
      widx_r <= 4'h0;
      err_r <= 1'b0;
      sts_r <= 8'h00;
      o_mem <= '0;
      o_exec_start <= 1'b0;
      o_exec <= '0;
      irq_issued_r <= 1'b0;
      for (int i = 0; i < dcl_pkg::BLK_WORDS; i++) begin
        blk_r[i] <= 16'h0000;
      end
    end else begin
      o_exec_start <= 1'b0;
      if (!ctrl_r[dcl_pkg::CTRL_IE_BIT]) begin
        irq_issued_r <= 1'b0;
      end
      if (host_byte_strobe && ctrl_r[dcl_pkg::CTRL_CMD_BIT] && !accept_r &&
          state_r == dcl_pkg::ST_IDLE) begin
        busy_r <= 1'b1;
      end
      case (state_r)
        dcl_pkg::ST_IDLE: begin
          if (boot_pend_r) begin
            state_r <= dcl_pkg::ST_BOOT;
          end else if (start_r) begin
            widx_r <= dcl_pkg::W_CMD;
            o_mem <= '{1'b1, 1'b0, word_addr(ptr_r, dcl_pkg::W_CMD),
                       16'h0000};
            state_r <= dcl_pkg::ST_FETCH;
          end
        end
        dcl_pkg::ST_FETCH: begin
          if (i_mem_ack) begin
            blk_r[widx_r] <= i_mem_rdata;
            if (widx_r == 4'(dcl_pkg::BLK_WORDS - 1)) begin
              o_mem.req <= 1'b0;
              state_r <= dcl_pkg::ST_EXEC;
            end else begin
              widx_r <= widx_r + 4'h1;
              o_mem.addr <= word_addr(ptr_r, widx_r + 4'h1);
            end
          end
        end
        dcl_pkg::ST_EXEC: begin
          o_exec_start <= 1'b1;
          o_exec.cmd <= blk_r[dcl_pkg::W_CMD];
          o_exec.count <= blk_r[dcl_pkg::W_COUNT];
          o_exec.host_addr <= {blk_r[dcl_pkg::W_HOST_HI][2:0],
                               blk_r[dcl_pkg::W_HOST_LO]};
          o_exec.disk_addr <= {blk_r[dcl_pkg::W_DISK_HI],
                               blk_r[dcl_pkg::W_DISK_LO]};
          state_r <= dcl_pkg::ST_WAIT;
        end
        dcl_pkg::ST_WAIT: begin
          if (i_exec_done) begin
            err_r <= i_exec_err;
            sts_r <= i_exec_status;
            o_mem <= '{1'b1, 1'b1, word_addr(ptr_r, dcl_pkg::W_STATUS),
                       {1'b1, i_exec_err, 6'h00, i_exec_status}};
            state_r <= dcl_pkg::ST_WSTAT;
          end
        end
        dcl_pkg::ST_WSTAT: begin
          if (i_mem_ack) begin
            o_mem.req <= 1'b0;
            o_mem.we <= 1'b0;
            if (ctrl_r[dcl_pkg::CTRL_IE_BIT] &&
                blk_r[dcl_pkg::W_CMD][dcl_pkg::CMD_IRQ_REQ_BIT]) begin
              irq_issued_r <= 1'b1;
            end
            if (err_r || link == 19'h00000) begin
              busy_r <= 1'b0;
              state_r <= dcl_pkg::ST_IDLE;
            end else begin
              widx_r <= dcl_pkg::W_CMD;
              o_mem <= '{1'b1, 1'b0, word_addr(link, dcl_pkg::W_CMD),
                         16'h0000};
              state_r <= dcl_pkg::ST_FETCH;
            end
          end
        end
        dcl_pkg::ST_BOOT: begin
          busy_r <= 1'b1;
          o_exec_start <= 1'b1;
          o_exec <= '{dcl_pkg::CMD_BOOT, dcl_pkg::BOOT_COUNT, 19'h00000,
                      32'h0000_0000};
          state_r <= dcl_pkg::ST_BWAIT;
        end
        dcl_pkg::ST_BWAIT: begin
          if (i_exec_done) begin
            busy_r <= 1'b0;
            state_r <= dcl_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= dcl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Boot after each release of the system reset, not on RESET bit
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      first_r <= 1'b1;
      boot_pend_r <= 1'b0;
      o_host_powerup_reset_line_b <= 1'b1;
    end else begin
      first_r <= 1'b0;
      if (first_r && i_boot_strap) begin
        boot_pend_r <= 1'b1;
      end else if (state_r == dcl_pkg::ST_BOOT) begin
        boot_pend_r <= 1'b0;
      end
      o_host_powerup_reset_line_b <= !(i_host_reset_strap &&
        (boot_pend_r || state_r == dcl_pkg::ST_BOOT ||
         state_r == dcl_pkg::ST_BWAIT));
    end
  end

  // Strapped interrupt level
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_host_irq <= '0;
    end else begin
      for (int i = 0; i < IRQ_LEVELS; i++) begin
        o_host_irq[i] <= irq_issued_r && (i_irq_level_strap == 4'(i));
      end
    end
  end

  // RAM guard; addresses pass unchanged, so loaded code runs in place
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_ram_we <= 1'b0;
      o_ram_wr_reject <= 1'b0;
      o_ram_addr <= 16'h0000;
      o_ram_wdata <= 16'h0000;
    end else begin
      o_ram_we <= i_ram_wr_valid && i_ram_wr_addr >= dcl_pkg::RAM_WR_LO &&
                  i_ram_wr_addr <= dcl_pkg::RAM_WR_HI;
      o_ram_wr_reject <= i_ram_wr_valid &&
        (i_ram_wr_addr < dcl_pkg::RAM_WR_LO ||
         i_ram_wr_addr > dcl_pkg::RAM_WR_HI);
      o_ram_addr <= i_ram_wr_addr;
      o_ram_wdata <= i_ram_wr_data;
    end
  end

  ram_guard_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    o_ram_we |-> $past(i_ram_wr_addr) >= 16'hFC06 &&
                 $past(i_ram_wr_addr) <= 16'hFFFE)
    else $error("RAM write outside window");
  accept_cue_a: assert property (@(posedge i_clk_sys) disable iff (core_rst)
    $rose(accept_r) |-> $past(host_byte_strobe))
    else $error("accept rose without cue");
  busy_cmd_a: assert property (@(posedge i_clk_sys) disable iff (core_rst)
    host_byte_strobe && ctrl_r[8] && !accept_r && state_r == dcl_pkg::ST_IDLE |=> busy_r)
    else $error("busy not set on command byte");
  status_done_a: assert property (@(posedge i_clk_sys) disable iff (core_rst)
    o_mem.req && o_mem.we |-> o_mem.wdata[15] && o_mem.addr == ptr_r)
    else $error("status write malformed");
  irq_gate_a: assert property (@(posedge i_clk_sys) disable iff (core_rst)
    $rose(irq_issued_r) |-> $past(ctrl_r[13]) && blk_r[1][15])
    else $error("interrupt without enables");
  error_stop_a: assert property (@(posedge i_clk_sys) disable iff (core_rst)
    state_r == dcl_pkg::ST_WSTAT && i_mem_ack && err_r
      |=> state_r == dcl_pkg::ST_IDLE && !busy_r)
    else $error("chain continued after error");
  fetch_range_a: assert property (@(posedge i_clk_sys) disable iff (core_rst)
    state_r == dcl_pkg::ST_FETCH && o_mem.req
      |-> o_mem.addr == word_addr(ptr_r, widx_r) ||
          o_mem.addr == word_addr(link, widx_r))
    else $error("fetch outside block");
  host_rst_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !o_host_powerup_reset_line_b |-> $past(i_host_reset_strap))
    else $error("host reset without strap");
  exec_seq_a: assert property (@(posedge i_clk_sys) disable iff (core_rst)
    state_r == dcl_pkg::ST_FETCH && i_mem_ack && widx_r == 4'h9
      |=> ##1 o_exec_start)
    else $error("command not started after fetch");
endmodule : dcl_ctrl

/* File: hw/dcl_pkg.sv */
/*
 Constants, types and register map of the command list controller.
 Assumes one 10 MHz system clock and an AXI4-Lite master for the host.
*/
package dcl_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_POINTER = 8'h08;
  // Control register fields, numbered as on the serial bit bus
  localparam int CTRL_CMD_BIT = 8;
  localparam int CTRL_CUE_BIT = 10;
  localparam int CTRL_IE_BIT = 13;
  localparam int CTRL_RST_BIT = 14;
  // Status register fields
  localparam int STS_ACCEPT_BIT = 11;
  localparam int STS_BUSY_BIT = 12;
  localparam int STS_IRQ_BIT = 15;
  // Command block layout, word indices
  localparam int BLK_WORDS = 10;
  localparam logic [3:0] W_STATUS = 4'h0;
  localparam logic [3:0] W_CMD = 4'h1;
  localparam logic [3:0] W_DISK_HI = 4'h2;
  localparam logic [3:0] W_DISK_LO = 4'h3;
  localparam logic [3:0] W_COUNT = 4'h4;
  localparam logic [3:0] W_HOST_HI = 4'h5;
  localparam logic [3:0] W_HOST_LO = 4'h6;
  localparam logic [3:0] W_LINK_HI = 4'h8;
  localparam logic [3:0] W_LINK_LO = 4'h9;
  localparam int CMD_IRQ_REQ_BIT = 15;
  localparam int STS_DONE_BIT = 15;
  localparam int STS_ERR_BIT = 14;
  localparam logic [1:0] PTR_BYTES = 2'h3;
  // Writable window of controller RAM
  localparam logic [15:0] RAM_WR_LO = 16'hFC06;
  localparam logic [15:0] RAM_WR_HI = 16'hFFFE;
  localparam logic [15:0] CMD_BOOT = 16'h0005;
  localparam logic [15:0] BOOT_COUNT = 16'h0080;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_EXEC = 3'b010,
    ST_WAIT = 3'b011,
    ST_WSTAT = 3'b100,
    ST_BOOT = 3'b101,
    ST_BWAIT = 3'b110
  } dcl_state_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [18:0] addr;
    logic [15:0] wdata;
  } dcl_mem_req_s;

  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] count;
    logic [18:0] host_addr;
    logic [31:0] disk_addr;
  } dcl_exec_s;
endpackage : dcl_pkg

/* File: verification/dcl_host_mem_model.sv */
/*
 Host memory model that answers the controller's bus master requests.
 Assumes req is held until ack and that word addresses are addr over two.
*/
`timescale 1ns/100ps
module dcl_host_mem_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Memory bus
  input wire dcl_pkg::dcl_mem_req_s i_mem,
  input wire logic i_slow,
  output logic o_mem_ack,
  output logic [15:0] o_mem_rdata
);
  logic [15:0] mem [logic [18:0]];
  logic [1:0] wait_r;

  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_mem_ack <= 1'b0;
      wait_r <= 2'h0;
      o_mem_rdata <= 16'h5A5A;
    end else begin
      o_mem_ack <= 1'b0;
      // Idle data toggles so a stale word is never mistaken for an answer
      o_mem_rdata <= ~o_mem_rdata;
      if (i_mem.req && !o_mem_ack) begin
        if (wait_r != 2'h0) begin
          wait_r <= wait_r - 2'h1;
        end else begin
          o_mem_ack <= 1'b1;
          wait_r <= i_slow ? 2'($urandom_range(1, 3)) : 2'h0;
          if (i_mem.we) begin
            mem[i_mem.addr >> 1] = i_mem.wdata;
          end else if (mem.exists(i_mem.addr >> 1)) begin
            o_mem_rdata <= mem[i_mem.addr >> 1];
          end
        end
      end
    end
  end
endmodule : dcl_host_mem_model

/* File: verification/disk_command_list_host_interface_tb.sv */
/*
 Self-checking bench for the command list controller.
 Assumes the host memory model beside it and a 10 MHz system clock.
*/
`timescale 1ns/100ps
module disk_command_list_host_interface_tb;
  localparam int ACC = dcl_pkg::STS_ACCEPT_BIT;
  localparam int BSY = dcl_pkg::STS_BUSY_BIT;
  localparam int IRQ = dcl_pkg::STS_IRQ_BIT;
  logic i_clk_sys, i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid;
  logic i_rready, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [7:0] i_awaddr, i_araddr, i_exec_status;
  logic [31:0] i_wdata, o_rdata, rd;
  logic [3:0] i_wstrb, i_irq_level_strap;
  logic [1:0] o_bresp, o_rresp, resp;
  dcl_pkg::dcl_mem_req_s o_mem;
  dcl_pkg::dcl_exec_s o_exec;
  logic i_mem_ack, i_slow, i_exec_done, i_exec_err, o_exec_start, ok;
  logic [15:0] i_mem_rdata, i_ram_wr_addr, i_ram_wr_data, o_ram_addr;
  logic [15:0] o_ram_wdata, o_host_irq;
  logic i_ram_wr_valid, o_ram_we, o_ram_wr_reject, i_boot_strap;
  logic i_host_reset_strap, o_host_powerup_reset_line_b;
  logic o_controller_attention_irq;
  logic [18:0] p, q, hst;
  logic [15:0] ga [6];
  logic [15:0] cm [2];
  logic [31:0] dk [2];
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;

  dcl_ctrl u_dcl_ctrl (
    .i_clk_sys, .i_rst_b, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
    .i_rready, .o_mem, .i_mem_ack, .i_mem_rdata, .o_exec_start, .o_exec,
    .i_exec_done, .i_exec_err, .i_exec_status, .i_ram_wr_valid,
    .i_ram_wr_addr, .i_ram_wr_data, .o_ram_we, .o_ram_addr, .o_ram_wdata,
    .o_ram_wr_reject, .i_boot_strap, .i_host_reset_strap,
    .i_irq_level_strap, .o_host_powerup_reset_line_b,
    .o_controller_attention_irq, .o_host_irq
  );
  dcl_host_mem_model u_dcl_host_mem_model (
    .i_clk_sys, .i_rst_b, .i_mem(o_mem), .i_slow,
    .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // Hang guard: whole run needs a few hundred cycles
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [95:0] e, g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge i_clk_sys);
      if (o_awready === 1'b1) i_awvalid <= 1'b0;
      if (o_wready === 1'b1) i_wvalid <= 1'b0;
      if (o_bvalid === 1'b1) break;
    end
    i_bready <= 1'b0;
    resp = o_bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge i_clk_sys);
      if (o_arready === 1'b1) i_arvalid <= 1'b0;
      if (o_rvalid === 1'b1) break;
    end
    i_rready <= 1'b0;
    rd = o_rdata;
    resp = o_rresp;
  endtask : axi_rd

  task automatic ctl(input logic [7:0] b, input logic c, u, e, r);
    axi_wr(dcl_pkg::REG_CTRL, {17'h0, r, e, 2'h0, u, 1'b0, c, b});
  endtask : ctl

  task automatic wait_sts(input int b, input logic v);
    for (int n = 0; n < 50; n++) begin
      axi_rd(dcl_pkg::REG_STATUS);
      if (rd[b] === v) break;
    end
  endtask : wait_sts

  task automatic send_ptr(input logic [18:0] a, input logic ie);
    logic [7:0] b [3];
    b = '{{4'h0, a[18:15]}, a[14:7], {a[6:0], 1'b0}};
    for (int i = 0; i < 3; i++) begin
      ctl(b[i], i == 0, 1'b0, ie, 1'b0);
      ctl(b[i], i == 0, 1'b1, ie, 1'b0);
      wait_sts(ACC, 1'b1);
      chk("accept busy cue", 3'h7,
          {rd[ACC], rd[BSY], o_controller_attention_irq});
      ctl(b[i], 1'b0, 1'b0, ie, 1'b0);
      wait_sts(ACC, 1'b0);
      chk("accept drop", 0, rd[ACC]);
    end
  endtask : send_ptr

  // Word zero starts clear so written status shows up
  task automatic load_blk(input logic [18:0] a, l, h, input logic [15:0] c,
                          input logic [31:0] d);
    logic [15:0] w [10];
    w = '{16'h0, c, d[31:16], d[15:0], 16'h0080, {13'h0, h[18:16]},
          h[15:0], 16'h0, {13'h0, l[18:16]}, l[15:0]};
    foreach (w[i]) u_dcl_host_mem_model.mem[(a >> 1) + 19'(i)] = w[i];
  endtask : load_blk

  task automatic wait_exec(input dcl_pkg::dcl_exec_s e);
    for (int n = 0; n < 300 && o_exec_start !== 1'b1; n++) begin
      @(posedge i_clk_sys);
    end
    chk("exec start", {1'b1, e}, {o_exec_start, o_exec});
  endtask : wait_exec

  task automatic fin_exec(input logic er, input logic [7:0] st);
    i_exec_done <= 1'b1;
    i_exec_err <= er;
    i_exec_status <= st;
    @(posedge i_clk_sys);
    i_exec_done <= 1'b0;
    i_exec_err <= 1'b0;
  endtask : fin_exec

  task automatic run_blk(input logic [18:0] a, input int k,
                         input logic er, irq);
    logic [7:0] st;
    st = 8'($urandom);
    wait_exec('{cm[k], 16'h0080, hst, dk[k]});
    fin_exec(er, st);
    // Bounded poll of word zero, as a careful host would
    for (int n = 0; n < 300; n++) begin
      @(posedge i_clk_sys);
      if (u_dcl_host_mem_model.mem[a >> 1] !== 16'h0) break;
    end
    chk("status word", {1'b1, er, 6'h0, st},
        u_dcl_host_mem_model.mem[a >> 1]);
    for (int n = 0; n < 10 && o_host_irq === 16'h0; n++) begin
      @(posedge i_clk_sys);
    end
    chk("host irq", irq ? 16'h1 << i_irq_level_strap : 16'h0,
        o_host_irq);
  endtask : run_blk

  initial begin
    void'($urandom(32'h62f266c5));
    {i_awaddr, i_araddr, i_awvalid, i_wvalid, i_bready, i_arvalid} = '0;
    {i_rready, i_wdata, i_slow, i_exec_done, i_exec_err} = '0;
    {i_exec_status, i_ram_wr_valid, i_ram_wr_addr, i_ram_wr_data} = '0;
    {i_boot_strap, i_host_reset_strap} = 2'h0;
    i_wstrb = 4'hF;
    i_rst_b = 1'b0;
    i_irq_level_strap = 4'($urandom);
    repeat (20) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    chk("idle lines", 17'h10000, {o_host_powerup_reset_line_b, o_host_irq});
    axi_rd(dcl_pkg::REG_STATUS);
    chk("status idle", 0, rd);
    axi_wr(8'h10, $urandom);
    chk("unmapped write", dcl_pkg::RESP_SLVERR, resp);
    axi_rd(8'h10);
    chk("unmapped read", {dcl_pkg::RESP_SLVERR, 32'h0}, {resp, rd});
    $display("test registers finished");
    ga = '{16'hFC05, 16'hFC06, 16'hFFFE, 16'hFFFF, 16'h0000, 16'($urandom)};
    foreach (ga[i]) begin
      @(posedge i_clk_sys);
      i_ram_wr_valid <= 1'b1;
      i_ram_wr_addr <= ga[i];
      i_ram_wr_data <= 16'($urandom);
      @(posedge i_clk_sys);
      i_ram_wr_valid <= 1'b0;
      @(posedge i_clk_sys);
      ok = ga[i] >= 16'hFC06 && ga[i] <= 16'hFFFE;
      chk("ram guard", {ok, !ok}, {o_ram_we, o_ram_wr_reject});
      if (ok) chk("ram write", {ga[i], i_ram_wr_data},
                  {o_ram_addr, o_ram_wdata});
    end
    $display("test ram guard finished");
    p = 19'($urandom_range(0, 32'h3FF00)) << 1;
    q = p + 19'h40;
    // Data buffer kept inside one 64 K page
    hst = {3'($urandom_range(0, 7)), 16'h1000};
    // First block asks for an interrupt, second does not
    cm = '{{8'h80, 8'($urandom)}, {8'h00, 8'($urandom)}};
    // Disk addresses keep the high word off zero, clear of side 0 track 0
    dk = '{{16'($urandom) | 16'h0100, 16'($urandom)},
           {16'($urandom) | 16'h0100, 16'($urandom)}};
    load_blk(p, q, hst, cm[0], dk[0]);
    load_blk(q, 19'h00100, hst, cm[1], dk[1]);
    send_ptr(p, 1'b1);
    axi_rd(dcl_pkg::REG_POINTER);
    chk("pointer", p, rd);
    run_blk(p, 0, 1'b0, 1'b1);
    axi_rd(dcl_pkg::REG_STATUS);
    chk("irq issued", 1, rd[IRQ]);
    i_slow <= 1'b1;
    ctl(8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    ctl(8'h00, 1'b0, 1'b0, 1'b1, 1'b0);
    chk("irq cleared", 0, o_host_irq);
    run_blk(q, 1, 1'b1, 1'b0);
    for (int n = 0; n < 100 && o_exec_start !== 1'b1; n++) begin
      @(posedge i_clk_sys);
    end
    chk("chain dropped", 0, o_exec_start);
    axi_rd(dcl_pkg::REG_STATUS);
    chk("busy after error", 0, rd[BSY]);
    $display("test chain finished");
    ctl(8'h00, 1'b1, 1'b1, 1'b0, 1'b0);
    wait_sts(BSY, 1'b1);
    chk("busy hung", 1, rd[BSY]);
    ctl(8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
    ctl(8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    axi_rd(dcl_pkg::REG_STATUS);
    chk("recovered", 0, {rd[ACC], rd[BSY]});
    $display("test reset bit finished");
    i_boot_strap <= 1'b1;
    i_host_reset_strap <= 1'b1;
    i_rst_b <= 1'b0;
    repeat (20) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    wait_exec('{dcl_pkg::CMD_BOOT, dcl_pkg::BOOT_COUNT, 19'h0, 32'h0});
    chk("host held", 0, o_host_powerup_reset_line_b);
    fin_exec(1'b0, 8'h00);
    repeat (3) @(posedge i_clk_sys);
    chk("host freed", 1, o_host_powerup_reset_line_b);
    $display("test boot finished");
    stop_test();
  end
endmodule : disk_command_list_host_interface_tb
